// >>> hw/ebi_pkg.sv
package ebi_pkg;
	// ==========================================
	// Widths
	localparam int EBI_ADDR_W = 23;
	localparam int EBI_LOW_W = 16;
	localparam int EBI_HIGH_W = 7;
	localparam int EBI_DATA_W = 16;
	localparam int EBI_NIRQ = 4;
	// ==========================================
	// Register offsets (word index on the register port)
	localparam logic [3:0] EBI_REG_BANK = 4'h0;
	localparam logic [3:0] EBI_REG_MASK = 4'h1;
	localparam logic [3:0] EBI_REG_IFR = 4'h2;
	localparam logic [3:0] EBI_REG_CTRL = 4'h3;
	localparam logic [3:0] EBI_REG_ISTAT = 4'h4;
	localparam logic [3:0] EBI_REG_IMASK = 4'h5;
	localparam logic [3:0] EBI_REG_PIN = 4'h6;
	// ==========================================
	// Field positions and reset values
	localparam int EBI_BANK_HOLDER_BIT = 0;
	localparam logic [15:0] EBI_BANK_RST = 16'h0001;
	localparam int EBI_CTRL_GMASK_BIT = 0;
	localparam logic [15:0] EBI_CTRL_RST = 16'h0001;
	localparam logic [3:0] EBI_MASK_RST = 4'h0;
	localparam logic [15:0] EBI_NMI_VEC = 16'h0078;
	localparam logic [15:0] EBI_INT_VEC0 = 16'h0080;
	localparam logic [15:0] EBI_VEC_STEP = 16'h0004;
	localparam int EBI_ACK_CYC = 2;
	// Status bits for the interrupt output
	localparam int EBI_EV_ACK = 0;
	localparam int EBI_EV_NMI = 1;
	localparam int EBI_EV_HOLD = 2;
	localparam int EBI_NEV = 3;
	// ==========================================
	// Bus cycle types
	typedef enum logic [1:0] {
		EBI_SP_PROG = 2'b00,
		EBI_SP_DATA = 2'b01,
		EBI_SP_IO = 2'b10
	} ebi_space_t;
endpackage

// >>> hw/ebi_sync.sv
`timescale 1ns/1ns
module ebi_sync #(
	parameter int W = 1
) (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic [W-1:0] d,
	output logic [W-1:0] q
);
	logic [W-1:0] meta_r;

	// ==========================================
	// Two stages; first stage read only here
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			meta_r <= '0;
			q <= '0;
		end else begin
			meta_r <= d;
			q <= meta_r;
		end
	end
endmodule

// >>> hw/ebi_irq.sv
`timescale 1ns/1ns
module ebi_irq
	import ebi_pkg::*;
#(
	parameter int N = EBI_NIRQ
) (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic [N-1:0] irq_low,
	input wire logic nmi_low,
	input wire logic [N-1:0] mask,
	input wire logic gmask,
	input wire logic busy,
	input wire logic [N-1:0] flag_clr,
	output logic [N-1:0] flag_r,
	output logic take,
	output logic take_nmi,
	output logic [1:0] take_idx
);
	logic [N-1:0] irq_d_r;
	logic nmi_d_r;
	logic nmi_pend_r;
	logic [N-1:0] fall;
	logic [N-1:0] ready;

	assign fall = irq_d_r & ~irq_low;
	assign ready = flag_r & mask;

	// ==========================================
	// Flags latch falling edges; set beats clear
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			irq_d_r <= '1;
			nmi_d_r <= 1'b1;
		end else begin
			irq_d_r <= irq_low;
			nmi_d_r <= nmi_low;
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			flag_r <= '0;
		end else begin
			flag_r <= (flag_r & ~flag_clr & ~(take && !take_nmi ?
				N'(1) << take_idx : '0)) | fall;
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			nmi_pend_r <= 1'b0;
		end else begin
			nmi_pend_r <= (nmi_pend_r && !(take && take_nmi)) ||
				(nmi_d_r && !nmi_low);
		end
	end

	// ==========================================
	// NMI ignores both masks; lowest input wins
	always_comb begin
		take = 1'b0;
		take_nmi = 1'b0;
		take_idx = 2'h0;
		if (!busy && nmi_pend_r) begin
			take = 1'b1;
			take_nmi = 1'b1;
		end else if (!busy && !gmask) begin
			for (int i = N - 1; i >= 0; i--) begin
				if (ready[i]) begin
					take = 1'b1;
					take_idx = 2'(i);
				end
			end
		end
	end
endmodule

// >>> hw/ebi_top.sv
// Contract
// - Low sixteen address lines serve every space
// - Upper seven lines only for program space
// - Address floats in hold or disable
// - Wide host select makes low address input
// - Sixteen-bit bidirectional data bus
// - Data floats unless writing, reset, hold
// - Disable low floats data bus
// - Holders keep last driven data level
// - Bank control register enables holders
// - Acknowledge pulses during vector fetch
// - Disable low floats acknowledge
// - Four inputs prioritized, individually maskable
// - Flag register shows pending inputs
// - Non-maskable input bypasses all masks
// - Non-maskable request traps to its vector
`timescale 1ns/1ns
module ebi_top
	import ebi_pkg::*;
#(
	parameter int AW = EBI_ADDR_W,
	parameter int DW = EBI_DATA_W
) (
	input wire logic core_clk,
	input wire logic resetn,
	// Core side bus request
	input wire logic core_req,
	input wire logic core_wr,
	input wire logic [1:0] core_space,
	input wire logic [AW-1:0] core_addr,
	input wire logic [DW-1:0] core_wdata,
	output logic core_ack,
	output logic [DW-1:0] core_rdata,
	// Pins
	input wire logic reset_n_in,
	input wire logic hold_n_in,
	output logic hold_ack_n_out,
	input wire logic out_en_n_in,
	input wire logic host_port_wide_select,
	input wire logic [EBI_LOW_W-1:0] addr_lsb_in,
	output logic [AW-1:0] addr_out,
	output logic [AW-1:0] addr_oe,
	output logic [EBI_LOW_W-1:0] host_port_addr,
	input wire logic [DW-1:0] data_in,
	output logic [DW-1:0] data_out,
	output logic [DW-1:0] data_oe,
	output logic [DW-1:0] host_port_rdata,
	output logic irq_ack_out,
	output logic irq_ack_oe,
	input wire logic [EBI_NIRQ-1:0] ext_irq_in,
	input wire logic nmi_n_in,
	output logic vec_valid,
	output logic [EBI_LOW_W-1:0] vec_addr,
	// Register port
	input wire logic [3:0] reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [15:0] reg_rdata,
	output logic irq_out
);
	localparam int PIN_W = EBI_NIRQ + 5;
	logic [PIN_W-1:0] pin_raw;
	logic [PIN_W-1:0] pin_sync;
	logic rst_s;
	logic hold_s;
	logic off_s;
	logic wide_s;
	logic nmi_s;
	logic [EBI_NIRQ-1:0] irq_s;
	logic [15:0] bank_switch_ctrl_reg;
	logic [EBI_NIRQ-1:0] irq_mask_reg;
	logic [15:0] ctrl_r;
	logic global_irq_mask_bit;
	logic [EBI_NIRQ-1:0] flag_r;
	logic [EBI_NIRQ-1:0] flag_clr;
	logic take;
	logic take_nmi;
	logic [1:0] take_idx;
	logic irq_busy;
	logic [1:0] ack_cnt_r;
	logic [EBI_LOW_W-1:0] vec_r;
	logic hold_r;
	logic [AW-1:0] addr_r;
	logic [DW-1:0] wdata_r;
	logic [DW-1:0] last_r;
	logic cyc_start;
	logic wr_active_r;
	logic cyc_r;
	logic space_prog_r;
	logic [EBI_NEV-1:0] istat_r;
	logic [EBI_NEV-1:0] imask_r;
	logic [EBI_NEV-1:0] ev;
	logic float_all;
	logic drive_data;
	logic bus_quiet;
	logic holder_on;

	// ==========================================
	// Pin synchronisers
	// Every control pin synced in its asserted sense, so reset reads idle
	assign pin_raw = {~reset_n_in, ~hold_n_in, ~out_en_n_in,
		host_port_wide_select, ~nmi_n_in, ~ext_irq_in};

	ebi_sync #(.W(PIN_W)) u_sync (
		.core_clk(core_clk),
		.resetn(resetn),
		.d(pin_raw),
		.q(pin_sync)
	);

	assign {rst_s, hold_s, off_s, wide_s, nmi_s, irq_s} = pin_sync;

	assign irq_busy = ack_cnt_r != 2'h0 || hold_r || rst_s;

	ebi_irq u_irq (
		.core_clk(core_clk),
		.resetn(resetn),
		.irq_low(~irq_s),
		.nmi_low(~nmi_s),
		.mask(irq_mask_reg),
		.gmask(global_irq_mask_bit),
		.busy(irq_busy),
		.flag_clr(flag_clr),
		.flag_r(flag_r),
		.take(take),
		.take_nmi(take_nmi),
		.take_idx(take_idx)
	);

	assign global_irq_mask_bit = ctrl_r[EBI_CTRL_GMASK_BIT];

	// ==========================================
	// Register write decode, shared by every writable word
	function automatic logic wr_hit(logic wr, logic [3:0] a,
		logic [3:0] target);
		return wr && (a == target);
	endfunction

	// ==========================================
	// Registers
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			bank_switch_ctrl_reg <= EBI_BANK_RST;
		end else if (wr_hit(reg_wr, reg_addr, EBI_REG_BANK)) begin
			bank_switch_ctrl_reg <= reg_wdata;
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			irq_mask_reg <= EBI_MASK_RST;
		end else if (wr_hit(reg_wr, reg_addr, EBI_REG_MASK)) begin
			irq_mask_reg <= reg_wdata[EBI_NIRQ-1:0];
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			ctrl_r <= EBI_CTRL_RST;
		end else if (wr_hit(reg_wr, reg_addr, EBI_REG_CTRL)) begin
			ctrl_r <= reg_wdata;
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			imask_r <= '0;
		end else if (wr_hit(reg_wr, reg_addr, EBI_REG_IMASK)) begin
			imask_r <= reg_wdata[EBI_NEV-1:0];
		end
	end

	assign flag_clr = wr_hit(reg_wr, reg_addr, EBI_REG_IFR) ?
		reg_wdata[EBI_NIRQ-1:0] : '0;

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			reg_rdata <= '0;
		end else if (reg_rd) begin
			unique case (reg_addr)
				EBI_REG_BANK: reg_rdata <= bank_switch_ctrl_reg;
				EBI_REG_MASK: reg_rdata <= 16'(irq_mask_reg);
				EBI_REG_IFR: reg_rdata <= 16'(flag_r);
				EBI_REG_CTRL: reg_rdata <= ctrl_r;
				EBI_REG_ISTAT: reg_rdata <= 16'(istat_r);
				EBI_REG_IMASK: reg_rdata <= 16'(imask_r);
				EBI_REG_PIN: reg_rdata <= {11'h000, hold_r, off_s, wide_s,
					rst_s, nmi_s};
				default: reg_rdata <= '0;
			endcase
		end else begin
			reg_rdata <= '0;
		end
	end

	// ==========================================
	// Interrupt status, write one to clear; set wins
	assign ev[EBI_EV_ACK] = take;
	assign ev[EBI_EV_NMI] = take && take_nmi;
	assign ev[EBI_EV_HOLD] = hold_s && !hold_r;

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			istat_r <= '0;
		end else begin
			istat_r <= (istat_r & ~(wr_hit(reg_wr, reg_addr, EBI_REG_ISTAT) ?
				reg_wdata[EBI_NEV-1:0] : '0)) | ev;
		end
	end

	assign irq_out = |(istat_r & imask_r);

	// ==========================================
	// Hold arbitration, granted between cycles
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			hold_r <= 1'b0;
		end else if (!cyc_r) begin
			hold_r <= hold_s;
		end
	end

	assign hold_ack_n_out = ~hold_r;

	// ==========================================
	// Bus cycle: one core cycle per access
	// Refused requests are not queued; the core keeps its request up
	assign cyc_start = core_req && !cyc_r && !bus_quiet;

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			cyc_r <= 1'h0;
			wr_active_r <= 1'h0;
		end else begin
			cyc_r <= cyc_start;
			wr_active_r <= cyc_start && core_wr;
		end
	end

	// Address and data stay after the cycle; the holder drives its own copy, last_r
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			addr_r <= '0;
			wdata_r <= '0;
			space_prog_r <= 1'h0;
		end else if (cyc_start) begin
			addr_r <= core_addr;
			wdata_r <= core_wdata;
			space_prog_r <= core_space == EBI_SP_PROG;
		end
	end

	assign core_ack = cyc_r;

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			core_rdata <= '0;
		end else if (cyc_r && !wr_active_r) begin
			core_rdata <= data_in;
		end
	end

	// ==========================================
	// Acknowledge and vector fetch
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			ack_cnt_r <= 2'h0;
		end else if (take) begin
			ack_cnt_r <= 2'(EBI_ACK_CYC);
		end else if (ack_cnt_r != 2'h0) begin
			ack_cnt_r <= ack_cnt_r - 2'h1;
		end
	end

	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			vec_r <= '0;
		end else if (take) begin
			vec_r <= take_nmi ? EBI_NMI_VEC :
				EBI_INT_VEC0 + EBI_VEC_STEP * 16'(take_idx);
		end
	end

	assign vec_valid = ack_cnt_r != 2'h0;
	assign vec_addr = vec_r;

	// ==========================================
	// Pin drivers; disable overrides all
	assign float_all = off_s || hold_r;
	// Vector fetch owns low lines while acknowledging
	always_comb begin
		addr_out = addr_r;
		if (vec_valid) begin
			addr_out = {EBI_HIGH_W'(0), vec_r};
		end else if (!space_prog_r) begin
			addr_out = {EBI_HIGH_W'(0), addr_r[EBI_LOW_W-1:0]};
		end
	end

	always_comb begin
		addr_oe = '0;
		if (!float_all) begin
			if (!wide_s) begin
				addr_oe[EBI_LOW_W-1:0] = '1;
			end
			if ((cyc_r && space_prog_r) && !vec_valid) begin
				addr_oe[AW-1:EBI_LOW_W] = '1;
			end
		end
	end

	assign host_port_addr = wide_s ? addr_lsb_in : '0;

	// Reset pin and hold, requested or granted, silence the data bus and stop new cycles
	assign bus_quiet = rst_s || hold_s || hold_r;
	assign drive_data = wr_active_r && !bus_quiet;

	// Holder remembers only what this end drove
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			last_r <= '0;
		end else if (drive_data && !off_s) begin
			last_r <= wdata_r;
		end
	end

	// Holder is a weak keeper: modelled as drive of the last value,
	// so it must yield to reads, hold and the reset pin
	assign holder_on = bank_switch_ctrl_reg[EBI_BANK_HOLDER_BIT];
	always_comb begin
		data_out = last_r;
		data_oe = '0;
		if (!off_s) begin
			if (drive_data) begin
				data_out = wdata_r;
				data_oe = '1;
			end else if (holder_on && !cyc_r && !bus_quiet) begin
				data_oe = '1;
			end
		end
	end

	assign host_port_rdata = wide_s ? data_in : '0;

	assign irq_ack_out = ~vec_valid;
	assign irq_ack_oe = !off_s;
endmodule

// >>> verification/ebi_top_props.sv
`timescale 1ns/1ns
module ebi_top_chk
	import ebi_pkg::*;
#(
	parameter int AW = EBI_ADDR_W,
	parameter int DW = EBI_DATA_W
) (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic core_wr,
	input wire logic [1:0] core_space,
	input wire logic [AW-1:0] core_addr,
	input wire logic [DW-1:0] core_wdata,
	input wire logic core_ack,
	input wire logic out_en_n_in,
	input wire logic hold_ack_n_out,
	input wire logic host_port_wide_select,
	input wire logic [EBI_LOW_W-1:0] addr_lsb_in,
	input wire logic [AW-1:0] addr_out,
	input wire logic [AW-1:0] addr_oe,
	input wire logic [EBI_LOW_W-1:0] host_port_addr,
	input wire logic [DW-1:0] data_out,
	input wire logic [DW-1:0] data_oe,
	input wire logic irq_ack_out,
	input wire logic irq_ack_oe,
	input wire logic nmi_n_in,
	input wire logic vec_valid,
	input wire logic [EBI_LOW_W-1:0] vec_addr
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!resetn);
	// ==========================================
	// Floating; three cycles cover the pin sync
	addr_off_a: assert property ((!out_en_n_in) [*3] |-> addr_oe == '0)
		else $error("address driven while disabled");
	data_off_a: assert property ((!out_en_n_in) [*3] |-> data_oe == '0)
		else $error("data driven while disabled");
	ack_off_a: assert property ((!out_en_n_in) [*3] |-> !irq_ack_oe)
		else $error("acknowledge driven while disabled");
	hold_float_a: assert property (!hold_ack_n_out |-> !(|addr_oe) && !(|data_oe))
		else $error("lines driven in hold");
	// ==========================================
	// Bus cycles
	low_addr_a: assert property (core_ack |-> addr_out[15:0] == $past(core_addr[15:0]))
		else $error("low address wrong");
	upper_only_prog_a: assert property (core_ack && $past(core_space) != EBI_SP_PROG
		|-> addr_oe[AW-1:EBI_LOW_W] == '0)
		else $error("upper address driven outside program space");
	write_data_a: assert property (core_ack && $past(core_wr)
		|-> data_out == $past(core_wdata))
		else $error("write data wrong");
	holder_keep_a: assert property (core_ack && $past(core_wr) ##1 !core_ack
		|-> $stable(data_out))
		else $error("data level not kept");
	host_addr_a: assert property (host_port_wide_select [*3]
		|-> !(|addr_oe[15:0]) && host_port_addr == addr_lsb_in)
		else $error("low address not an input");
	// ==========================================
	// Interrupts
	ack_vec_a: assert property ($rose(vec_valid)
		|-> !irq_ack_out ##1 (vec_valid && !irq_ack_out))
		else $error("acknowledge not with vector fetch");
	nmi_trap_a: assert property ($fell(nmi_n_in)
		|-> ##[1:12] (vec_valid && vec_addr == EBI_NMI_VEC))
		else $error("non-maskable request not trapped");
	cover property (vec_valid && vec_addr == EBI_NMI_VEC);
	cover property (!hold_ack_n_out);
	cover property (core_ack && $past(core_wr));
endmodule

bind ebi_top ebi_top_chk #(.AW(AW), .DW(DW)) ebi_top_chk_i (.core_clk,
	.resetn, .core_wr, .core_space, .core_addr, .core_wdata, .core_ack,
	.out_en_n_in, .hold_ack_n_out, .host_port_wide_select, .addr_lsb_in,
	.addr_out, .addr_oe, .host_port_addr, .data_out, .data_oe,
	.irq_ack_out, .irq_ack_oe, .nmi_n_in, .vec_valid, .vec_addr);

// >>> verification/ebi_mem_model.sv
`timescale 1ns/1ns
module ebi_mem_model (
	input wire logic [22:0] addr_out,
	input wire logic [15:0] data_oe,
	input wire logic [15:0] data_out,
	output logic [15:0] data_in
);
	// ==========================================
	// Wire level: each bit is the device where it
	// drives, else the memory's address pattern
	assign data_in = (data_oe & data_out)
		| (~data_oe & (addr_out[15:0] ^ 16'h5a5a));
endmodule

// >>> verification/ebi_top_test.sv
`timescale 1ns/1ns
module ebi_top_test;
	import ebi_pkg::*;
	logic core_clk = 1'b0, resetn = 1'b0, core_req = 1'b0, core_wr = 1'b0;
	logic reset_n_in = 1'b1, hold_n_in = 1'b1, out_en_n_in = 1'b1;
	logic nmi_n_in = 1'b1, host_port_wide_select = 1'b0;
	logic reg_wr = 1'b0, reg_rd = 1'b0;
	logic [1:0] core_space = 2'h0;
	logic [22:0] core_addr = 23'h0, addr_out, addr_oe;
	logic [15:0] core_wdata = 16'h0, reg_wdata = 16'h0, addr_lsb_in = 16'h0;
	logic [15:0] data_in, core_rdata, host_port_addr, data_out, data_oe;
	logic [15:0] host_port_rdata, vec_addr, reg_rdata;
	logic [3:0] ext_irq_in = 4'hf, reg_addr = 4'h0;
	logic core_ack, hold_ack_n_out, irq_ack_out, irq_ack_oe;
	logic vec_valid, irq_out;
	int fails = 0, check_count = 0, cyc = 0;
	ebi_top ebi_top_i (.core_clk, .resetn, .core_req, .core_wr, .core_space,
		.core_addr, .core_wdata, .core_ack, .core_rdata, .reset_n_in,
		.hold_n_in, .hold_ack_n_out, .out_en_n_in, .host_port_wide_select,
		.addr_lsb_in, .addr_out, .addr_oe, .host_port_addr, .data_in,
		.data_out, .data_oe, .host_port_rdata, .irq_ack_out, .irq_ack_oe,
		.ext_irq_in, .nmi_n_in, .vec_valid, .vec_addr, .reg_addr, .reg_wdata,
		.reg_wr, .reg_rd, .reg_rdata, .irq_out);
	ebi_mem_model ebi_mem_model_i (.addr_out, .data_oe, .data_out, .data_in);
	always #10 core_clk = ~core_clk;
	// ==========================================
	// Tasks
	task automatic cmp(string n, logic [22:0] e, logic [22:0] g);
		check_count++;
		if (g !== e) begin
			fails++;
			$display("CHECK FAILED %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic tick(int n);
		repeat (n) @(negedge core_clk);
	endtask
	task automatic wait_for(int k);
		repeat (30) begin
			@(negedge core_clk);
			if (k == 0 && core_ack === 1'b1 || k == 1 && vec_valid === 1'b1
				|| k == 2 && hold_ack_n_out === 1'b0) break;
		end
	endtask
	task automatic wreg(logic [3:0] a, logic [15:0] d);
		@(posedge core_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rreg(logic [3:0] a, logic [15:0] e);
		@(posedge core_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		@(negedge core_clk);
		cmp("reg", e, reg_rdata);
	endtask
	// Request is taken at the first edge; no hold meanwhile
	task automatic acc(logic w, logic [1:0] s, logic [22:0] a, logic [15:0] d);
		@(posedge core_clk);
		core_req <= 1'b1;
		core_wr <= w;
		core_space <= s;
		core_addr <= a;
		core_wdata <= d;
		@(posedge core_clk);
		core_req <= 1'b0;
		wait_for(0);
		cmp("ack", 1'b1, core_ack);
	endtask
	task automatic vec(logic [15:0] e);
		wait_for(1);
		cmp("vec", e, vec_addr);
		cmp("ack_pin", 1'b0, irq_ack_out);
		tick(3);
	endtask
	task automatic finish_test();
		$display("checks %0d fails %0d", check_count, fails);
		if (fails == 0 && check_count > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 2000) begin
			fails++;
			finish_test();
		end
	end
	// ==========================================
	// Sequence
	initial begin
		repeat (4) @(posedge core_clk);
		resetn <= 1'b1;
		rreg(EBI_REG_BANK, EBI_BANK_RST);
		rreg(EBI_REG_MASK, 16'h0);
		rreg(EBI_REG_CTRL, EBI_CTRL_RST);
		rreg(4'hf, 16'h0);
		acc(1'b1, EBI_SP_PROG, 23'h5abcde, 16'h1234);
		cmp("hi_oe", 23'h7f0000, addr_oe & 23'h7f0000);
		cmp("wdata", 16'h1234, data_out);
		tick(2);
		cmp("keep_oe", 16'hffff, data_oe);
		acc(1'b1, EBI_SP_DATA, 23'h7f4321, 16'hc3c3);
		cmp("hi_off", 23'h0, addr_oe & 23'h7f0000);
		cmp("lo_addr", 23'h4321, addr_out & 23'hffff);
		acc(1'b0, EBI_SP_IO, 23'h000077, 16'h0);
		cmp("rd_oe", 16'h0, data_oe);
		tick(1);
		cmp("rdata", 16'h0077 ^ 16'h5a5a, core_rdata);
		cmp("keep", 16'hc3c3, data_out);
		@(posedge core_clk) reset_n_in <= 1'b0;
		tick(3);
		cmp("rst_d", 16'h0, data_oe);
		rreg(EBI_REG_PIN, 16'h0002);
		@(posedge core_clk) reset_n_in <= 1'b1;
		tick(3);
		wreg(EBI_REG_BANK, 16'h0);
		tick(3);
		cmp("no_keep", 16'h0, data_oe);
		wreg(EBI_REG_BANK, 16'h1);
		@(posedge core_clk) hold_n_in <= 1'b0;
		wait_for(2);
		cmp("hold_ack", 1'b0, hold_ack_n_out);
		cmp("hold_a", 23'h0, addr_oe);
		cmp("hold_d", 16'h0, data_oe);
		@(posedge core_clk) hold_n_in <= 1'b1;
		@(posedge core_clk) out_en_n_in <= 1'b0;
		tick(4);
		cmp("off_a", 23'h0, addr_oe);
		cmp("off_d", 16'h0, data_oe);
		cmp("off_k", 1'b0, irq_ack_oe);
		@(posedge core_clk) out_en_n_in <= 1'b1;
		@(posedge core_clk) host_port_wide_select <= 1'b1;
		addr_lsb_in <= 16'hbeef;
		tick(4);
		cmp("hp_addr", 16'hbeef, host_port_addr);
		cmp("hp_oe", 23'h0, addr_oe & 23'hffff);
		cmp("hp_data", 16'hc3c3, host_port_rdata);
		@(posedge core_clk) host_port_wide_select <= 1'b0;
		wreg(EBI_REG_CTRL, 16'h0);
		@(posedge core_clk) ext_irq_in <= 4'b0101;
		tick(6);
		rreg(EBI_REG_IFR, 16'h000a);
		cmp("masked", 1'b0, vec_valid);
		wreg(EBI_REG_MASK, 16'h000f);
		vec(EBI_INT_VEC0 + 16'h0004);
		vec(EBI_INT_VEC0 + 16'h000c);
		@(posedge core_clk) ext_irq_in <= 4'hf;
		wreg(EBI_REG_CTRL, 16'h1);
		@(posedge core_clk) nmi_n_in <= 1'b0;
		vec(EBI_NMI_VEC);
		@(posedge core_clk) nmi_n_in <= 1'b1;
		wreg(EBI_REG_IMASK, 16'h0002);
		tick(2);
		cmp("irq_on", 1'b1, irq_out);
		wreg(EBI_REG_ISTAT, 16'h0002);
		tick(2);
		cmp("irq_off", 1'b0, irq_out);
		finish_test();
	end
endmodule
